// *** rtl/transceiver_power_mode_ctrl.sv ***
// The address-and-strobe port and the register offsets were chosen for this implementation.
`default_nettype none
module transceiver_power_mode_ctrl
  import xcvr_pkg::*;
(
  // Clock and reset
  input  wire logic        clock,
  input  wire logic        rst,
  // Register port
  input  wire logic [7:0]  addr,
  input  wire logic [31:0] wdata,
  input  wire logic        wr,
  input  wire logic        rd,
  output logic      [31:0] rdata,
  // Mode pins from the baseband controller
  input  wire logic        receive_mode_pin,
  input  wire logic        transmit_mode_pin,
  input  wire logic        synth_mode_pin,
  // Reference and oscillator signals
  input  wire logic        ref_in,
  input  wire logic        rf_lo_in,
  input  wire logic        if_lo_in,
  // Power enables
  output power_en_t        power,
  // Offset correction
  output offset_t          i_offset,
  output offset_t          q_offset,
  // Charge pump commands
  output logic             rf_pump_source,
  output logic             rf_pump_sink,
  output logic             if_pump_source,
  output logic             if_pump_sink,
  // Quadrature IF LO
  output logic             if_lo_0deg,
  output logic             if_lo_90deg
);

  ////////////////////////////////////////////////////////////////
  // Registers

  logic [5:0]          mode_ctrl_q;
  logic [13:0]         offset_q;
  logic [RF_DIV_W-1:0] rf_div_q;
  logic [IF_DIV_W-1:0] if_div_q;
  op_mode_t            mode_q;
  op_mode_t            mode_d;

  // Software writes, one word per strobe
  always_ff @(posedge clock) begin
    if (rst) begin
      mode_ctrl_q <= MODE_CTRL_RESET;
      offset_q    <= OFFSET_RESET;
      rf_div_q    <= RF_DIV_RESET;
      if_div_q    <= IF_DIV_RESET;
    end else if (wr) begin
      case (addr)
        MODE_CTRL_ADDR: mode_ctrl_q <= wdata[5:0];
        OFFSET_ADDR:    offset_q    <= wdata[13:0];
        RF_DIV_ADDR:    rf_div_q    <= wdata[RF_DIV_W-1:0];
        IF_DIV_ADDR:    if_div_q    <= wdata[IF_DIV_W-1:0];
        default:        ;
      endcase
    end
  end

  // Read data stands only in the cycle after the strobe
  always_ff @(posedge clock) begin
    if (rst || !rd) begin
      rdata <= 32'h0000_0000;
    end else begin
      case (addr)
        MODE_CTRL_ADDR: rdata <= {26'h0, mode_ctrl_q};
        OFFSET_ADDR:    rdata <= {18'h0, offset_q};
        RF_DIV_ADDR:    rdata <= {18'h0, rf_div_q};
        IF_DIV_ADDR:    rdata <= {24'h0, if_div_q};
        STATUS_ADDR:    rdata <= {22'h0, mode_q, power};
        default:        rdata <= 32'h0000_0000;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////
  // Mode decode

  logic req_rx;
  logic req_tx;
  logic req_synth;

  // Pin or programmed bit, active high
  assign req_rx    = receive_mode_pin  || mode_ctrl_q[RX_BIT];
  assign req_tx    = transmit_mode_pin || mode_ctrl_q[TX_BIT];
  assign req_synth = synth_mode_pin    || mode_ctrl_q[SYNTH_BIT];

  // Single legal mode; receive beats transmit if both asked
  always_comb begin
    if (req_rx) begin
      mode_d = MODE_RX;
    end else if (req_tx) begin
      mode_d = MODE_TX;
    end else if (req_synth) begin
      mode_d = MODE_SYNTH;
    end else begin
      mode_d = MODE_IDLE;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      mode_q <= MODE_IDLE;
    end else begin
      mode_q <= mode_d;
    end
  end

  ////////////////////////////////////////////////////////////////
  // Power enables

  // Decoded from the next mode so enables track it without lag;
  // only one of receive and transmit can ever be set
  always_ff @(posedge clock) begin
    if (rst) begin
      power <= '0;
    end else begin
      power <= '0;
      case (mode_d)
        MODE_SYNTH: begin
          power.synth  <= 1'b1;
          power.osc    <= 1'b1;
          power.lo_buf <= 1'b1;
        end
        MODE_RX: begin
          power.synth    <= 1'b1;
          power.osc      <= 1'b1;
          power.lo_buf   <= 1'b1;
          power.rx       <= 1'b1;
          power.demod    <= 1'b1;
          power.rx_front <= mode_ctrl_q[FRONT_BIT];
          power.low_noise_amp_enable_bit      <= mode_ctrl_q[FRONT_BIT]
                            && mode_ctrl_q[LNA_BIT];
        end
        MODE_TX: begin
          power.synth  <= 1'b1;
          power.osc    <= 1'b1;
          power.lo_buf <= 1'b1;
          power.tx     <= 1'b1;
        end
        default: power <= '0;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////
  // Offset correction

  always_ff @(posedge clock) begin
    if (rst) begin
      i_offset <= '0;
      q_offset <= '0;
    end else begin
      i_offset.mag      <= offset_q[I_MAG_LSB +: OFS_W];
      i_offset.positive <= offset_q[I_SIGN_BIT];
      q_offset.mag      <= offset_q[Q_MAG_LSB +: OFS_W];
      q_offset.positive <= offset_q[Q_SIGN_BIT];
    end
  end

  ////////////////////////////////////////////////////////////////
  // Edge detection of reference and oscillator inputs

  logic ref_prev_q;
  logic rf_prev_q;
  logic if_prev_q;
  logic ref_rise;
  logic rf_rise;
  logic if_rise;
  logic if_fall;

  always_ff @(posedge clock) begin
    if (rst) begin
      ref_prev_q <= 1'b0;
      rf_prev_q  <= 1'b0;
      if_prev_q  <= 1'b0;
    end else begin
      ref_prev_q <= ref_in;
      rf_prev_q  <= rf_lo_in;
      if_prev_q  <= if_lo_in;
    end
  end

  assign ref_rise = ref_in && !ref_prev_q;
  assign rf_rise  = rf_lo_in && !rf_prev_q;
  assign if_rise  = if_lo_in && !if_prev_q;
  assign if_fall  = !if_lo_in && if_prev_q;

  ////////////////////////////////////////////////////////////////
  // Dual divider chain and detectors

  logic loops_on;
  logic ref_rf_pulse;
  logic ref_if_pulse;
  logic rf_lo_pulse;
  logic if_lo_pulse;

  // Loops idle with the synthesizer to save switching power
  assign loops_on = power.synth;

  // Reference down to the 200 kHz and 1 MHz comparison rates
  pulse_divider ref_rf_div (
    .clock (clock),
    .rst   (rst),
    .run   (loops_on),
    .ratio (REF_RF_RATIO),
    .tick  (ref_rise),
    .pulse (ref_rf_pulse)
  );

  pulse_divider ref_if_div (
    .clock (clock),
    .rst   (rst),
    .run   (loops_on),
    .ratio (REF_IF_RATIO),
    .tick  (ref_rise),
    .pulse (ref_if_pulse)
  );

  // Programmable LO dividers
  pulse_divider rf_lo_div (
    .clock (clock),
    .rst   (rst),
    .run   (loops_on),
    .ratio (rf_div_q),
    .tick  (rf_rise),
    .pulse (rf_lo_pulse)
  );

  pulse_divider if_lo_div (
    .clock (clock),
    .rst   (rst),
    .run   (loops_on),
    .ratio ({6'h00, if_div_q}),
    .tick  (if_rise),
    .pulse (if_lo_pulse)
  );

  phase_freq_detector rf_pfd (
    .clock     (clock),
    .rst       (rst),
    .run       (loops_on),
    .ref_pulse (ref_rf_pulse),
    .lo_pulse  (rf_lo_pulse),
    .source_q  (rf_pump_source),
    .sink_q    (rf_pump_sink)
  );

  phase_freq_detector if_pfd (
    .clock     (clock),
    .rst       (rst),
    .run       (loops_on),
    .ref_pulse (ref_if_pulse),
    .lo_pulse  (if_lo_pulse),
    .source_q  (if_pump_source),
    .sink_q    (if_pump_sink)
  );

  ////////////////////////////////////////////////////////////////
  // Quadrature IF LO

  // Toggling on rising and falling edges halves the rate and
  // puts the two outputs a quarter period apart
  always_ff @(posedge clock) begin
    if (rst || !loops_on) begin
      if_lo_0deg  <= 1'b0;
      if_lo_90deg <= 1'b0;
    end else begin
      if (if_rise) begin
        if_lo_0deg <= !if_lo_0deg;
      end
      if (if_fall) begin
        if_lo_90deg <= if_lo_0deg;
      end
    end
  end

endmodule
`default_nettype wire

// *** rtl/xcvr_pkg.sv ***
`default_nettype none
package xcvr_pkg;

  // Register map, byte addresses on the plain register port
  localparam logic [7:0] MODE_CTRL_ADDR = 8'h00;
  localparam logic [7:0] OFFSET_ADDR    = 8'h04;
  localparam logic [7:0] RF_DIV_ADDR    = 8'h08;
  localparam logic [7:0] IF_DIV_ADDR    = 8'h0C;
  localparam logic [7:0] STATUS_ADDR    = 8'h10;

  // Mode control fields
  localparam int TX_BIT    = 0;
  localparam int RX_BIT    = 1;
  localparam int SYNTH_BIT = 2;
  localparam int FRONT_BIT = 4;
  localparam int LNA_BIT   = 5;
  localparam logic [5:0] MODE_CTRL_RESET = 6'h30;

  // Offset fields: magnitude then sign, I low, Q high
  localparam int OFS_W      = 5;
  localparam int I_MAG_LSB  = 0;
  localparam int I_SIGN_BIT = 5;
  localparam int Q_MAG_LSB  = 8;
  localparam int Q_SIGN_BIT = 13;
  localparam logic [13:0] OFFSET_RESET = 14'h0000;

  // Divider ratio widths and resets
  localparam int RF_DIV_W = 14;
  localparam int IF_DIV_W = 8;
  localparam logic [13:0] RF_DIV_RESET = 14'h0001;
  localparam logic [7:0]  IF_DIV_RESET = 8'h01;

  // Reference and comparison rates
  localparam int CLOCK_HZ  = 25_000_000;
  localparam int REF_HZ    = 13_000_000;
  localparam int RF_CMP_HZ = 200_000;
  localparam int IF_CMP_HZ = 1_000_000;
  localparam logic [13:0] REF_RF_RATIO = 14'(REF_HZ / RF_CMP_HZ);
  localparam logic [13:0] REF_IF_RATIO = 14'(REF_HZ / IF_CMP_HZ);

  // Operating modes
  typedef enum logic [1:0] {
    MODE_IDLE  = 2'b00,
    MODE_SYNTH = 2'b01,
    MODE_RX    = 2'b10,
    MODE_TX    = 2'b11
  } op_mode_t;

  // Power enables that leave the block together
  typedef struct packed {
    logic synth;
    logic osc;
    logic lo_buf;
    logic rx;
    logic demod;
    logic rx_front;
    logic low_noise_amp_enable_bit;
    logic tx;
  } power_en_t;

  // Offset correction for one output pair
  typedef struct packed {
    logic           positive;
    logic [OFS_W-1:0] mag;
  } offset_t;

endpackage
`default_nettype wire

// *** rtl/pulse_divider.sv ***
`default_nettype none
module pulse_divider
  import xcvr_pkg::*;
(
  // Clock and reset
  input  wire logic        clock,
  input  wire logic        rst,
  // Control
  input  wire logic        run,
  input  wire logic [13:0] ratio,
  // Events
  input  wire logic        tick,
  output logic             pulse
);

  logic [13:0] count_q;
  logic        last;

  // Ratio of 0 behaves as 1, so the chain never stalls
  assign last = (ratio <= 14'h0001) || (count_q == ratio - 14'h0001);

  // Count input events; restart while the loop is unpowered
  always_ff @(posedge clock) begin
    if (rst || !run) begin
      count_q <= 14'h0000;
      pulse   <= 1'b0;
    end else begin
      pulse <= tick && last;
      if (tick) begin
        count_q <= last ? 14'h0000 : count_q + 14'h0001;
      end
    end
  end

endmodule
`default_nettype wire

// *** rtl/phase_freq_detector.sv ***
`default_nettype none
module phase_freq_detector
(
  // Clock and reset
  input  wire logic clock,
  input  wire logic rst,
  input  wire logic run,
  // Divided reference and divided LO
  input  wire logic ref_pulse,
  input  wire logic lo_pulse,
  // Charge pump commands
  output logic      source_q,
  output logic      sink_q
);

  logic both;

  // Both states reached: detector resets, no pump current
  assign both = (source_q || ref_pulse) && (sink_q || lo_pulse);

  // Reference leads: source into filter; LO leads: sink
  always_ff @(posedge clock) begin
    if (rst || !run || both) begin
      source_q <= 1'b0;
      sink_q   <= 1'b0;
    end else begin
      source_q <= source_q || ref_pulse;
      sink_q   <= sink_q || lo_pulse;
    end
  end

endmodule
`default_nettype wire

// *** verif/xcvr_assertions.sv ***
`default_nettype none
module xcvr_assertions
  import xcvr_pkg::*;
(
  // Clock and reset
  input wire logic      clock,
  input wire logic      rst,
  // Mode request and power
  input wire logic      receive_mode_pin,
  input wire power_en_t power,
  // Loop and quadrature outputs
  input wire logic      rf_pump_source,
  input wire logic      rf_pump_sink,
  input wire logic      if_lo_0deg,
  input wire logic      if_lo_90deg
);
  default clocking @(posedge clock); endclocking
  default disable iff (rst);

  // Loops stopped with the synthesizer; the RF detector must fall quiet
  sequence loops_stopped;
    !power.synth;
  endsequence

  AST_NOT_ALL_ON: assert property (!(power.synth && power.rx && power.tx))
    else $error("all three sections on");
  AST_SYNTH_GROUP: assert property (power.osc == power.synth && power.lo_buf == power.synth)
    else $error("oscillator group split from synth");
  AST_RX_DEMOD: assert property (power.demod == power.rx)
    else $error("demodulator split from receiver");
  AST_NEEDS_SYNTH: assert property ((power.rx || power.tx) |-> power.synth)
    else $error("section on without synth");
  AST_RX_PIN: assert property (receive_mode_pin |=> power.rx && !power.tx)
    else $error("receive pin not obeyed");
  AST_IDLE_OFF: assert property (!power.synth |-> power == '0)
    else $error("idle with a section on");
  AST_FRONT_LNA: assert property ((power.low_noise_amp_enable_bit || power.rx_front) |-> (power.rx_front && power.rx))
    else $error("front or amplifier on outside receive");
  AST_PUMP_CLEAR: assert property (loops_stopped |=> !rf_pump_source && !rf_pump_sink)
    else $error("pump commands not cleared");
  // Stopping the loops clears both phases at once, so only running loops count
  AST_QUAD: assert property ($changed(if_lo_0deg) && $past(power.synth) |-> $stable(if_lo_90deg))
    else $error("quadrature phases moved together");
endmodule

////////////////////////////////////////////////////////////////////////////////
bind transceiver_power_mode_ctrl xcvr_assertions chk (
  .clock(clock), .rst(rst), .receive_mode_pin(receive_mode_pin), .power(power),
  .rf_pump_source(rf_pump_source), .rf_pump_sink(rf_pump_sink),
  .if_lo_0deg(if_lo_0deg), .if_lo_90deg(if_lo_90deg));
`default_nettype wire

// *** verif/lo_source.sv ***
`default_nettype none
module lo_source #(
  parameter int REF_HALF = 1,
  parameter int RF_HALF  = 2,
  parameter int IF_HALF  = 3
) (
  // Clock and reset
  input  wire logic clock,
  input  wire logic rst,
  // Oscillator levels
  output logic      ref_in,
  output logic      rf_lo_in,
  output logic      if_lo_in
);
  timeunit 1ns;
  timeprecision 1ps;
  int         cnt [3] = '{0, 0, 0};
  logic [2:0] lvl = 3'h0;
  int         half [3];

  assign half = '{REF_HALF, RF_HALF, IF_HALF};
  assign ref_in = lvl[0];
  assign rf_lo_in = lvl[1];
  assign if_lo_in = lvl[2];

  // Free square waves; reset restarts them so phases repeat run to run
  always_ff @(posedge clock) begin
    for (int i = 0; i < 3; i++) begin
      if (rst || cnt[i] == half[i] - 1) begin
        cnt[i] <= 0;
        lvl[i] <= rst ? 1'b0 : ~lvl[i];
      end else begin
        cnt[i] <= cnt[i] + 1;
      end
    end
  end
endmodule
`default_nettype wire

// *** verif/tb_top.sv ***
`default_nettype none
module tb_top
  import xcvr_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clock = 1'b0;
  logic        rst = 1'b1;
  logic [7:0]  addr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic        wr = 1'b0;
  logic        rd = 1'b0;
  logic        receive_mode_pin = 1'b0;
  logic        transmit_mode_pin = 1'b0;
  logic        synth_mode_pin = 1'b0;
  logic [31:0] rdata;
  logic        ref_in, rf_lo_in, if_lo_in;
  power_en_t   power;
  offset_t     i_offset, q_offset;
  logic        rf_pump_source, rf_pump_sink, if_pump_source, if_pump_sink;
  logic        if_lo_0deg, if_lo_90deg;
  int          num_errors = 0;
  int          total_checks = 0;
  logic [7:0]  ra [6] = '{MODE_CTRL_ADDR, OFFSET_ADDR, RF_DIV_ADDR, IF_DIV_ADDR, STATUS_ADDR, 8'h14};
  logic [31:0] rv [6] = '{32'h30, 32'h0, 32'h1, 32'h1, 32'h0, 32'h0};
  logic [5:0]  mv [8] = '{6'h02, 6'h12, 6'h32, 6'h22, 6'h01, 6'h04, 6'h03, 6'h30};

  transceiver_power_mode_ctrl DUT (
    .clock(clock), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
    .receive_mode_pin(receive_mode_pin), .transmit_mode_pin(transmit_mode_pin),
    .synth_mode_pin(synth_mode_pin), .ref_in(ref_in), .rf_lo_in(rf_lo_in),
    .if_lo_in(if_lo_in), .power(power), .i_offset(i_offset), .q_offset(q_offset),
    .rf_pump_source(rf_pump_source), .rf_pump_sink(rf_pump_sink),
    .if_pump_source(if_pump_source), .if_pump_sink(if_pump_sink),
    .if_lo_0deg(if_lo_0deg), .if_lo_90deg(if_lo_90deg));

  lo_source osc (.clock(clock), .rst(rst), .ref_in(ref_in), .rf_lo_in(rf_lo_in),
    .if_lo_in(if_lo_in));

  ////////////////////////////////////////////////////////////////////////////////
  // Clock
  always #20 clock = ~clock;

  // Comparison and verdict
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic summarize;
    if (num_errors == 0 && total_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  // Register port master: one-cycle strobes, data in the cycle after a read
  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clock);
    wr <= 1'b0;
  endtask

  task automatic rd_reg(input logic [7:0] a, output logic [31:0] d);
    @(posedge clock);
    addr <= a;
    rd <= 1'b1;
    @(posedge clock);
    rd <= 1'b0;
    #1 d = rdata;
  endtask

  // Expected status word; receive beats transmit beats synth-only
  function automatic logic [31:0] status_exp(input logic rx, tx, syn, front, low_noise_amp_enable_bit);
    logic [1:0] m;
    logic [7:0] p;
    m = rx ? 2'h2 : tx ? 2'h3 : syn ? 2'h1 : 2'h0;
    p = (m == 2'h0) ? 8'h00 : 8'hE0;
    if (m == 2'h2) p = p | 8'h18 | {5'h0, front, front & low_noise_amp_enable_bit, 1'b0};
    if (m == 2'h3) p = p | 8'h01;
    return {22'h0, m, p};
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // Hang guard, far beyond the few thousand cycles the run needs
  initial begin
    #1ms;
    num_errors++;
    summarize();
  end

  // Main sequence
  initial begin
    logic [31:0] v;
    logic [3:0]  seen;
    logic        l0, l90;
    int          t0, t90;
    repeat (5) @(posedge clock);
    rst <= 1'b0;
    for (int i = 0; i < 6; i++) begin
      rd_reg(ra[i], v);
      chk(v, rv[i]);
    end
    // Every pin combination, with front and amplifier bits at reset value
    for (int p = 0; p < 8; p++) begin
      @(posedge clock);
      receive_mode_pin <= p[0];
      transmit_mode_pin <= p[1];
      synth_mode_pin <= p[2];
      rd_reg(STATUS_ADDR, v);
      chk(v, status_exp(p[0], p[1], p[2], 1'b1, 1'b1));
    end
    @(posedge clock);
    receive_mode_pin <= 1'b0;
    transmit_mode_pin <= 1'b0;
    synth_mode_pin <= 1'b0;
    // Mode by programmed bits, front and amplifier gating
    foreach (mv[i]) begin
      wr_reg(MODE_CTRL_ADDR, {26'h0, mv[i]});
      rd_reg(STATUS_ADDR, v);
      chk(v, status_exp(mv[i][RX_BIT], mv[i][TX_BIT], mv[i][SYNTH_BIT],
          mv[i][FRONT_BIT], mv[i][LNA_BIT]));
    end
    // Field widths: upper bits are dropped
    for (int i = 1; i < 4; i++) begin
      wr_reg(ra[i], 32'hFFFF_FFFF);
      rd_reg(ra[i], v);
      chk(v, i == 1 ? 32'h3FFF : i == 2 ? 32'h3FFF : 32'hFF);
    end
    wr_reg(OFFSET_ADDR, 32'h0000_2015);
    wr_reg(RF_DIV_ADDR, 32'h1);
    wr_reg(IF_DIV_ADDR, 32'h1);
    chk({26'h0, i_offset}, 32'h15);
    chk({26'h0, q_offset}, 32'h20);
    // Synth-only, divided LOs faster than reference: sink only; IF LO halved
    wr_reg(MODE_CTRL_ADDR, 32'h34);
    repeat (12) @(posedge clock);
    #1;
    seen = 4'h0;
    t0 = 0;
    t90 = 0;
    l0 = if_lo_0deg;
    l90 = if_lo_90deg;
    for (int i = 0; i < 420; i++) begin
      @(posedge clock);
      #1;
      seen = seen | {if_pump_sink, if_pump_source, rf_pump_sink, rf_pump_source};
      t0 += int'(if_lo_0deg !== l0);
      t90 += int'(if_lo_90deg !== l90);
      l0 = if_lo_0deg;
      l90 = if_lo_90deg;
    end
    chk({28'h0, seen}, 32'hA);
    chk(t0, 32'd70);
    chk(t90, 32'd70);
    // Divided LOs slower than reference: after settling, source only
    wr_reg(RF_DIV_ADDR, 32'h28);
    wr_reg(IF_DIV_ADDR, 32'h5);
    repeat (1000) @(posedge clock);
    seen = 4'h0;
    for (int i = 0; i < 420; i++) begin
      @(posedge clock);
      #1;
      seen = seen | {if_pump_sink, if_pump_source, rf_pump_sink, rf_pump_source};
    end
    chk({28'h0, seen}, 32'h5);
    // Back to Idle: everything off, pumps quiet
    wr_reg(MODE_CTRL_ADDR, 32'h30);
    repeat (4) @(posedge clock);
    seen = 4'h0;
    for (int i = 0; i < 50; i++) begin
      @(posedge clock);
      #1;
      seen = seen | {if_pump_sink, if_pump_source, rf_pump_sink, rf_pump_source};
    end
    chk({28'h0, seen}, 32'h0);
    chk({24'h0, power}, 32'h0);
    summarize();
  end
endmodule
`default_nettype wire
